//--- dv/peripheral_irq_flag_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flag_bank_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic [31:0] rng = 32'h00013841;
    logic pready, pslverr, g3 = 1'b0, g1 = 1'b0, o2 = 1'b0, o1 = 1'b0;
    logic [3:0] which = 4'h0;
    logic [7:0] chg_set = 8'h00, chg_clr = 8'h00, chg_q, pins = 8'h00, rv;
    logic [15:0] p;
    logic [1:0] m2 = 2'h3, m1 = 2'h3;
    logic [32:0] expq[$];
    logic [32:0] me;
    int n_fail = 0, checks_done = 0;
    logic [7:0] tbl[16] = '{8'h05, 8'h0F, 8'h0D, 8'h0B, 8'h0A, 8'h08, 8'h17,
        8'h16, 8'h15, 8'h14, 8'h13, 8'h13, 8'h12, 8'h12, 8'h11, 8'h10};
    always #2.5 pclk = ~pclk;
    pifb_src pifb_src_inst (.pclk(pclk), .presetn(presetn), .fire(fire),
        .which(which), .chg_set(chg_set), .chg_clr(chg_clr), .pulse(p),
        .chg_q(chg_q));
    pirq_flag_bank pirq_flag_bank_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_zero_ovf(p[0]), .per_port_change_flags(chg_q), .ext_pins(pins),
        .timer_two_evt(p[1]), .timer_three_gate_active(g3),
        .timer_three_evt(p[2]), .timer_one_gate_active(g1),
        .timer_one_evt(p[3]), .clock_tuning_evt(p[4]), .nvm_op_done(p[5]),
        .logic_cell_two_evt(p[6]), .logic_cell_one_evt(p[7]),
        .waveform_gen_evt(p[8]), .num_osc_evt(p[9]), .cap_cmp_two_mode(m2),
        .cap_cmp_two_capture(p[10]), .cap_cmp_two_match(p[11]),
        .cap_cmp_two_out(o2), .cap_cmp_one_mode(m1),
        .cap_cmp_one_capture(p[12]), .cap_cmp_one_match(p[13]),
        .cap_cmp_one_out(o1), .timer_six_evt(p[14]), .timer_four_evt(p[15]),
        .request_flags_z(), .request_flags_a(), .request_flags_b());
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction
    task automatic fail(input logic [32:0] got, input logic [32:0] exp);
        n_fail++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [7:0] d, input logic [32:0] e, input logic f);
        int n;
        @(posedge pclk);
        if (!w) expq.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {rng[31:8], d};
        rng = xs(rng);
        @(posedge pclk);
        penable <= 1'b1;
        fire <= f;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail(33'h000000000, 33'h000000001);
            tally_and_finish();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
            fire <= 1'b0;
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        apb(1'b0, a, 8'h00, {25'h0000000, d}, 1'b0);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 33'h000000000, 1'b0);
    endtask
    task automatic kick(input logic [3:0] i);
        @(posedge pclk);
        which <= i;
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
    endtask
    task automatic chg(input logic [7:0] s, input logic [7:0] c);
        chg_set <= s;
        chg_clr <= c;
        @(posedge pclk);
        chg_set <= 8'h00;
        chg_clr <= 8'h00;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            me = expq.pop_front();
            checks_done++;
            if ({pslverr, prdata} !== me) fail({pslverr, prdata}, me);
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int r = 0; r < 3; r++) rd(12'h230 + 4 * r, 8'h00);
        rd(12'h280, 8'h00);
        apb(1'b0, 12'h3FC, 8'h00, 33'h100000000, 1'b0);
        wr(12'h234, 8'hFF);
        rd(12'h234, 8'hFD);
        wr(12'h234, 8'h00);
        for (int i = 0; i < 16; i++) begin
            m2 <= (i == 11) ? 2'h1 : 2'h0;
            m1 <= (i == 13) ? 2'h1 : 2'h0;
            kick(i[3:0]);
            rv = 8'h01 << tbl[i][2:0];
            rd(12'h230 + 4 * tbl[i][4:3], rv);
            wr(12'h230 + 4 * tbl[i][4:3], 8'h00);
        end
        which <= 4'h3;
        apb(1'b1, 12'h234, 8'h00, 33'h000000000, 1'b1);
        rd(12'h234, 8'h08);
        wr(12'h234, 8'h00);
        g1 <= 1'b1;
        g3 <= 1'b1;
        rd(12'h234, 8'h00);
        g1 <= 1'b0;
        g3 <= 1'b0;
        rd(12'h234, 8'h50);
        m2 <= 2'h2;
        m1 <= 2'h2;
        o2 <= 1'b1;
        o1 <= 1'b1;
        rd(12'h238, 8'h00);
        o2 <= 1'b0;
        o1 <= 1'b0;
        rd(12'h238, 8'h0C);
        m2 <= 2'h3;
        m1 <= 2'h3;
        kick(4'hA);
        kick(4'hD);
        rd(12'h238, 8'h0C);
        chg(8'h81, 8'h00);
        rd(12'h230, 8'h10);
        wr(12'h230, 8'h00);
        chg(8'h00, 8'h01);
        rd(12'h230, 8'h10);
        chg(8'h00, 8'h80);
        rd(12'h230, 8'h00);
        for (int k = 0; k < 3; k++) begin
            rv = rng[7:0];
            wr(12'h280, rv);
            rd(12'h280, rv);
        end
        wr(12'h280, 8'h83);
        repeat (4) @(posedge pclk);
        wr(12'h230, 8'h00);
        pins <= 8'h01;
        repeat (4) @(posedge pclk);
        rd(12'h230, 8'h00);
        pins <= 8'h09;
        repeat (4) @(posedge pclk);
        rd(12'h230, 8'h01);
        wr(12'h230, 8'h00);
        wr(12'h280, 8'h82);
        wr(12'h280, 8'h80);
        repeat (4) @(posedge pclk);
        rd(12'h230, 8'h00);
        @(posedge pclk);
        if (expq.size() != 0) fail(33'h000000000, 33'h000000001);
        tally_and_finish();
    end
endmodule
bind pirq_flag_bank pifb_chk #(.NUM_CHG(NUM_CHG)) pifb_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .timer_zero_ovf(timer_zero_ovf),
    .per_port_change_flags(per_port_change_flags),
    .timer_one_evt(timer_one_evt),
    .timer_one_gate_active(timer_one_gate_active),
    .nvm_op_done(nvm_op_done), .cap_cmp_two_mode(cap_cmp_two_mode),
    .cap_cmp_two_capture(cap_cmp_two_capture),
    .cap_cmp_two_match(cap_cmp_two_match), .num_osc_evt(num_osc_evt),
    .request_flags_z(request_flags_z), .request_flags_a(request_flags_a),
    .request_flags_b(request_flags_b));
`default_nettype wire

//--- dv/pifb_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pifb_chk #(
    parameter NUM_CHG = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic timer_zero_ovf,
    input wire logic [NUM_CHG-1:0] per_port_change_flags,
    input wire logic timer_one_evt,
    input wire logic timer_one_gate_active,
    input wire logic nvm_op_done,
    input wire logic [1:0] cap_cmp_two_mode,
    input wire logic cap_cmp_two_capture,
    input wire logic cap_cmp_two_match,
    input wire logic num_osc_evt,
    input wire logic [7:0] request_flags_z,
    input wire logic [7:0] request_flags_a,
    input wire logic [7:0] request_flags_b
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic wr = psel && penable && pwrite;
    a_chg_summary: assert property (request_flags_z[4] == |per_port_change_flags)
        else $error("summary flag wrong");
    a_tmr0_set: assert property (timer_zero_ovf |=> request_flags_z[5])
        else $error("timer zero flag not set");
    a_tmr0_hold: assert property (request_flags_z[5] && !(wr && paddr == 12'h230)
        |=> request_flags_z[5]) else $error("timer zero flag lost");
    a_tmr1_set: assert property (timer_one_evt |=> request_flags_a[3])
        else $error("timer one flag not set");
    a_tmr1_quiet: assert property (!request_flags_a[3] && !timer_one_evt
        && !(wr && paddr == 12'h234 && pwdata[3]) |=> !request_flags_a[3])
        else $error("timer one flag set alone");
    a_gate_fall: assert property ($fell(timer_one_gate_active)
        |=> request_flags_a[4]) else $error("gate flag not set");
    a_bit1_zero: assert property (request_flags_a[1] == 1'b0)
        else $error("unused bit set");
    a_nvm_set: assert property (nvm_op_done |=> request_flags_a[0])
        else $error("memory flag not set");
    a_cap_set: assert property (cap_cmp_two_mode == 2'h0 && cap_cmp_two_capture
        |=> request_flags_b[3]) else $error("capture flag not set");
    a_cmp_set: assert property (cap_cmp_two_mode == 2'h1 && cap_cmp_two_match
        |=> request_flags_b[3]) else $error("compare flag not set");
    a_osc_clear: assert property (wr && paddr == 12'h238 && !pwdata[4]
        && !num_osc_evt |=> !request_flags_b[4]) else $error("clear failed");
endmodule
`default_nettype wire

//--- dv/pifb_src.sv
`timescale 1ns/1ps
`default_nettype none
module pifb_src (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire,
    input wire logic [3:0] which,
    input wire logic [7:0] chg_set,
    input wire logic [7:0] chg_clr,
    output logic [15:0] pulse,
    output logic [7:0] chg_q
);
    // Events fire with no regard to any enable
    assign pulse = fire ? (16'h0001 << which) : 16'h0000;
    // Port flags fall only on reset or when their chg_clr bits are driven, any number in one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_q <= 8'h00;
        end else begin
            chg_q <= (chg_q | chg_set) & ~chg_clr;
        end
    end
endmodule
`default_nettype wire

//--- include/pirq_map.vh
`ifndef PIRQ_MAP_VH
`define PIRQ_MAP_VH

// Register indices; the byte address is four times the index
`define PIRQ_IDX_Z 10'h08C
`define PIRQ_IDX_A 10'h08D
`define PIRQ_IDX_B 10'h08E
`define PIRQ_IDX_SEL 10'h0A0

`define PIRQ_ADDR_W 12
`define PIRQ_REG_W 8
`define PIRQ_DATA_W 32
`define PIRQ_PAD_ZERO 24'h000000

// Reset values
`define PIRQ_FLAGS_RST 8'h00
`define PIRQ_SEL_RST 8'h00

// Implemented bits of each flag register
`define PIRQ_Z_IMPL 8'h21
`define PIRQ_A_IMPL 8'hFD
`define PIRQ_B_IMPL 8'hFF

// First request register
`define PIRQ_Z_TMR0 5
`define PIRQ_Z_CHG 4
`define PIRQ_Z_EXT 0

// Second request register
`define PIRQ_A_TMR2 7
`define PIRQ_A_T3G 6
`define PIRQ_A_TMR3 5
`define PIRQ_A_T1G 4
`define PIRQ_A_TMR1 3
`define PIRQ_A_ACT 2
`define PIRQ_A_NVM 0

// Third request register
`define PIRQ_B_LC2 7
`define PIRQ_B_LC1 6
`define PIRQ_B_CWG 5
`define PIRQ_B_NCO 4
`define PIRQ_B_CC2 3
`define PIRQ_B_CC1 2
`define PIRQ_B_TMR6 1
`define PIRQ_B_TMR4 0

// External pin select register fields
`define PIRQ_SEL_POL 7

// Capture/compare unit modes
`define PIRQ_CC_CAPTURE 2'h0
`define PIRQ_CC_COMPARE 2'h1
`define PIRQ_CC_PWM 2'h2

`endif

//--- rtl/pirq_flag_bank.v
// Function
// - Timer zero overflow sets bit 5, sticky
// - Bit 4 reads OR of port change flags
// - External pin event sets bit 0
// - External pin chosen by select register
// - Flags set regardless of any enable
// - Timer two event sets bit 7, sticky
// - Timer three/one gate inactive sets 6/4
// - Timer one gate flag latches on inactive
// - Timer three/one events latch bits 5/3
// - Timer one flag zero until event or a write of bit 3
// - Clock tuning event latches bit 2
// - Memory operation done sets bit 0
// - Logic cells two/one latch bits 7/6
// - Waveform and oscillator events latch 5/4
// - Capture mode: capture sets bit 3
// - Compare mode: match sets unit two flag
// - PWM mode: trailing edge sets flag
// - Unit one, timer six, four: 2/1/0
`timescale 1ns/1ps
`default_nettype none
`include "pirq_map.vh"

module pirq_flag_bank #(
    parameter NUM_CHG = 8,
    parameter EXT_SEL_W = 3
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PIRQ_ADDR_W-1:0] paddr,
    input wire [`PIRQ_DATA_W-1:0] pwdata,
    output reg [`PIRQ_DATA_W-1:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire timer_zero_ovf,
    input wire [NUM_CHG-1:0] per_port_change_flags,
    input wire [(1<<EXT_SEL_W)-1:0] ext_pins,
    input wire timer_two_evt,
    input wire timer_three_gate_active,
    input wire timer_three_evt,
    input wire timer_one_gate_active,
    input wire timer_one_evt,
    input wire clock_tuning_evt,
    input wire nvm_op_done,
    input wire logic_cell_two_evt,
    input wire logic_cell_one_evt,
    input wire waveform_gen_evt,
    input wire num_osc_evt,
    input wire [1:0] cap_cmp_two_mode,
    input wire cap_cmp_two_capture,
    input wire cap_cmp_two_match,
    input wire cap_cmp_two_out,
    input wire [1:0] cap_cmp_one_mode,
    input wire cap_cmp_one_capture,
    input wire cap_cmp_one_match,
    input wire cap_cmp_one_out,
    input wire timer_six_evt,
    input wire timer_four_evt,
    output wire [7:0] request_flags_z,
    output wire [7:0] request_flags_a,
    output wire [7:0] request_flags_b
);

    localparam NUM_EXT = 1 << EXT_SEL_W;

    // Picks the event that counts for the unit's current mode
    function cc_event;
        input [1:0] mode;
        input capture;
        input match;
        input trail;
        begin
            case (mode)
                `PIRQ_CC_CAPTURE: begin
                    cc_event = capture;
                end
                `PIRQ_CC_COMPARE: begin
                    cc_event = match;
                end
                `PIRQ_CC_PWM: begin
                    cc_event = trail;
                end
                default: begin
                    cc_event = 1'b0;
                end
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire [`PIRQ_ADDR_W-3:0] reg_idx;
    wire hit_z;
    wire hit_a;
    wire hit_b;
    wire hit_sel;
    wire hit_any;
    wire acc_wr;

    assign reg_idx = paddr[`PIRQ_ADDR_W-1:2];
    assign hit_z = (reg_idx == `PIRQ_IDX_Z);
    assign hit_a = (reg_idx == `PIRQ_IDX_A);
    assign hit_b = (reg_idx == `PIRQ_IDX_B);
    assign hit_sel = (reg_idx == `PIRQ_IDX_SEL);
    assign hit_any = hit_z | hit_a | hit_b | hit_sel;
    assign acc_wr = psel & penable & pwrite & pready;

    // No wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    wire wr_z;
    wire wr_a;
    wire wr_b;
    wire wr_sel;
    wire [7:0] wr_byte;

    assign wr_z = acc_wr & hit_z;
    assign wr_a = acc_wr & hit_a;
    assign wr_b = acc_wr & hit_b;
    assign wr_sel = acc_wr & hit_sel;
    assign wr_byte = pwdata[`PIRQ_REG_W-1:0];

    // ------------------------------------------------------------
    // External pin select register
    // ------------------------------------------------------------
    reg [7:0] sel_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= `PIRQ_SEL_RST;
        end else if (wr_sel) begin
            sel_q <= wr_byte;
        end
    end

    // ------------------------------------------------------------
    // External pins: two-stage synchroniser, then edge detect
    // ------------------------------------------------------------
    reg [NUM_EXT-1:0] ext_meta_q;
    reg [NUM_EXT-1:0] ext_sync_q;
    reg ext_prev_q;
    reg ext_resel_q;
    reg ext_raw_edge;
    wire ext_level;
    wire ext_edge;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta_q <= {NUM_EXT{1'b0}};
            ext_sync_q <= {NUM_EXT{1'b0}};
        end else begin
            ext_meta_q <= ext_pins;
            ext_sync_q <= ext_meta_q;
        end
    end

    // Pin picked by the select register
    assign ext_level = ext_sync_q[sel_q[EXT_SEL_W-1:0]];

    // After a new selection the new pin is compared with the old one
    // for one cycle; that step is masked so it raises no false flag,
    // at the cost of missing a real edge in that same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_q <= 1'b0;
            ext_resel_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_level;
            ext_resel_q <= wr_sel;
        end
    end

    // Polarity bit high selects the rising edge
    always @* begin
        if (sel_q[`PIRQ_SEL_POL]) begin
            ext_raw_edge = ext_level & ~ext_prev_q;
        end else begin
            ext_raw_edge = ~ext_level & ext_prev_q;
        end
    end

    assign ext_edge = ext_raw_edge & ~ext_resel_q;

    // ------------------------------------------------------------
    // Edge detectors on gate and waveform levels
    // ------------------------------------------------------------
    reg t1g_prev_q;
    reg t3g_prev_q;
    reg cc1_out_prev_q;
    reg cc2_out_prev_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1g_prev_q <= 1'b0;
            t3g_prev_q <= 1'b0;
            cc1_out_prev_q <= 1'b0;
            cc2_out_prev_q <= 1'b0;
        end else begin
            t1g_prev_q <= timer_one_gate_active;
            t3g_prev_q <= timer_three_gate_active;
            cc1_out_prev_q <= cap_cmp_one_out;
            cc2_out_prev_q <= cap_cmp_two_out;
        end
    end

    wire t1g_fall;
    wire t3g_fall;
    wire cc1_trail;
    wire cc2_trail;

    assign t1g_fall = t1g_prev_q & ~timer_one_gate_active;
    assign t3g_fall = t3g_prev_q & ~timer_three_gate_active;
    assign cc1_trail = cc1_out_prev_q & ~cap_cmp_one_out;
    assign cc2_trail = cc2_out_prev_q & ~cap_cmp_two_out;

    // ------------------------------------------------------------
    // Set vectors; no enable takes part in any of them
    // ------------------------------------------------------------
    reg [7:0] set_z;
    reg [7:0] set_a;
    reg [7:0] set_b;

    always @* begin
        set_z = `PIRQ_FLAGS_RST;
        set_z[`PIRQ_Z_TMR0] = timer_zero_ovf;
        set_z[`PIRQ_Z_EXT] = ext_edge;
    end

    always @* begin
        set_a = `PIRQ_FLAGS_RST;
        set_a[`PIRQ_A_TMR2] = timer_two_evt;
        set_a[`PIRQ_A_T3G] = t3g_fall;
        set_a[`PIRQ_A_TMR3] = timer_three_evt;
        set_a[`PIRQ_A_T1G] = t1g_fall;
        set_a[`PIRQ_A_TMR1] = timer_one_evt;
        set_a[`PIRQ_A_ACT] = clock_tuning_evt;
        set_a[`PIRQ_A_NVM] = nvm_op_done;
    end

    always @* begin
        set_b = `PIRQ_FLAGS_RST;
        set_b[`PIRQ_B_LC2] = logic_cell_two_evt;
        set_b[`PIRQ_B_LC1] = logic_cell_one_evt;
        set_b[`PIRQ_B_CWG] = waveform_gen_evt;
        set_b[`PIRQ_B_NCO] = num_osc_evt;
        set_b[`PIRQ_B_CC2] = cc_event(cap_cmp_two_mode,
            cap_cmp_two_capture, cap_cmp_two_match, cc2_trail);
        set_b[`PIRQ_B_CC1] = cc_event(cap_cmp_one_mode,
            cap_cmp_one_capture, cap_cmp_one_match, cc1_trail);
        set_b[`PIRQ_B_TMR6] = timer_six_evt;
        set_b[`PIRQ_B_TMR4] = timer_four_evt;
    end

    // ------------------------------------------------------------
    // Sticky flag registers
    // ------------------------------------------------------------
    wire [7:0] flags_z_store;

    // Summary bit is not stored, so writes to it do nothing
    pirq_flag_reg #(
        .IMPL(`PIRQ_Z_IMPL),
        .RST(`PIRQ_FLAGS_RST)
    ) u_flags_z (
        .pclk(pclk),
        .presetn(presetn),
        .set(set_z),
        .wr_en(wr_z),
        .wr_data(wr_byte),
        .flags(flags_z_store)
    );

    pirq_flag_reg #(
        .IMPL(`PIRQ_A_IMPL),
        .RST(`PIRQ_FLAGS_RST)
    ) u_flags_a (
        .pclk(pclk),
        .presetn(presetn),
        .set(set_a),
        .wr_en(wr_a),
        .wr_data(wr_byte),
        .flags(request_flags_a)
    );

    pirq_flag_reg #(
        .IMPL(`PIRQ_B_IMPL),
        .RST(`PIRQ_FLAGS_RST)
    ) u_flags_b (
        .pclk(pclk),
        .presetn(presetn),
        .set(set_b),
        .wr_en(wr_b),
        .wr_data(wr_byte),
        .flags(request_flags_b)
    );

    wire chg_any;

    assign chg_any = |per_port_change_flags;

    reg [7:0] flags_z_view;

    always @* begin
        flags_z_view = flags_z_store;
        flags_z_view[`PIRQ_Z_CHG] = chg_any;
    end

    assign request_flags_z = flags_z_view;

    // ------------------------------------------------------------
    // Read data, loaded in the setup cycle
    // ------------------------------------------------------------
    reg [7:0] rd_byte;

    always @* begin
        rd_byte = `PIRQ_FLAGS_RST;
        if (hit_z) begin
            rd_byte = flags_z_view;
        end else if (hit_a) begin
            rd_byte = request_flags_a;
        end else if (hit_b) begin
            rd_byte = request_flags_b;
        end else if (hit_sel) begin
            rd_byte = sel_q;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= {`PIRQ_PAD_ZERO, `PIRQ_FLAGS_RST};
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= {`PIRQ_PAD_ZERO, rd_byte};
        end
    end

endmodule
`default_nettype wire

//--- rtl/pirq_flag_reg.v
`timescale 1ns/1ps
`default_nettype none
`include "pirq_map.vh"

module pirq_flag_reg #(
    parameter [7:0] IMPL = 8'hFF,
    parameter [7:0] RST = 8'h00
) (
    input wire pclk,
    input wire presetn,
    input wire [7:0] set,
    input wire wr_en,
    input wire [7:0] wr_data,
    output wire [7:0] flags
);

    genvar i;
    generate
        for (i = 0; i < `PIRQ_REG_W; i = i + 1) begin : g_bit
            if (IMPL[i]) begin : g_impl
                reg flag_q;
                wire flag_d;
                // Hardware set wins over a software clear
                assign flag_d = set[i] | (wr_en ? wr_data[i] : flag_q);
                always @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        flag_q <= RST[i];
                    end else begin
                        flag_q <= flag_d;
                    end
                end
                assign flags[i] = flag_q;
            end else begin : g_none
                assign flags[i] = 1'b0;
            end
        end
    endgenerate

endmodule
`default_nettype wire
